//--- rtl/adc_accumulator.sv
`default_nettype none
module adc_accumulator (
  // Clock and reset.
  input  wire logic                              core_clk,
  input  wire logic                              rst_b,
  // Control.
  input  wire logic                              clear,
  input  wire logic                              signed_mode,
  input  wire adc_avg_pkg::conv_rsp_t            add,
  // Running sum.
  output logic [adc_avg_pkg::ACC_W-1:0]          sum,
  output logic                                   added
);

  // ****************************************************************
  // Running sum.
  // ****************************************************************
  logic [adc_avg_pkg::ACC_W-1:0] next_sum;
  logic [adc_avg_pkg::ACC_W-1:0] ext;
  logic                          next_added;

  // Signed samples are sign extended; unsigned ones never are.
  always_comb
  begin
    ext = signed_mode ? adc_avg_pkg::ACC_W'($signed(add.sample))
                      : adc_avg_pkg::ACC_W'(add.sample);
    next_sum   = sum;
    next_added = 1'b0;
    if (clear)
      next_sum = '0;
    else if (add.valid)
    begin
      next_sum   = sum + ext;
      next_added = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sum   <= '0;
      added <= 1'b0;
    end
    else
    begin
      sum   <= next_sum;
      added <= next_added;
    end
  end

endmodule // adc_accumulator
`default_nettype wire

//--- rtl/adc_averaging_sequencer.sv
// The register addresses and the Avalon-MM register port were decided locally.
`default_nettype none
module adc_averaging_sequencer (
  // Clock and reset.
  input  wire logic                               core_clk,
  input  wire logic                               rst_b,
  // Avalon-MM slave.
  input  wire logic [adc_avg_pkg::ADDR_W-1:0]     avs_address,
  input  wire logic                               avs_read,
  input  wire logic                               avs_write,
  input  wire logic [31:0]                        avs_writedata,
  output logic [31:0]                             avs_readdata,
  output logic                                    avs_waitrequest,
  // Analog core.
  output adc_avg_pkg::conv_req_t                  conv_req,
  input  wire adc_avg_pkg::conv_rsp_t             conv_rsp,
  // Trigger event from another domain.
  input  wire logic                               trig_event,
  // Interrupt.
  output logic                                    irq
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_CONVERT, ST_FINISH} state_t;

  state_t                                  state, next_state;
  logic [adc_avg_pkg::CTRL_W-1:0]          ctrl, next_ctrl;
  logic [adc_avg_pkg::LOG2_W-1:0]          avg_log2, next_avg_log2;
  logic [adc_avg_pkg::CH_W-1:0]            scan_base, next_scan_base;
  logic [adc_avg_pkg::CH_W-1:0]            scan_cnt, next_scan_cnt;
  logic [adc_avg_pkg::SAMPLE_W-1:0]        offset, next_offset;
  logic [adc_avg_pkg::SAMPLE_W-1:0]        result, next_result;
  logic                                    flag, next_flag;
  logic                                    mask, next_mask;
  logic                                    ack, next_ack;
  logic [31:0]                             next_readdata;
  logic [adc_avg_pkg::CH_W-1:0]            cur_ch, next_cur_ch;
  logic [adc_avg_pkg::CNT_W-1:0]           smp_cnt, next_smp_cnt;
  logic [adc_avg_pkg::CNT_W-1:0]           last_cnt;
  logic [2:0]                              evt_sync;
  logic                                    evt_level, next_evt_level;
  logic                                    evt_rise;
  logic                                    start_taken, trigger, acc_clear;
  logic                                    bus_wr;
  adc_avg_pkg::conv_rsp_t                  corr;
  logic [adc_avg_pkg::ACC_W-1:0]           acc_sum;
  logic                                    acc_added;
  logic                                    en, signed_mode;

  assign en          = ctrl[adc_avg_pkg::CTRL_ENABLE];
  assign signed_mode = ctrl[adc_avg_pkg::CTRL_SIGNED];
  assign last_cnt    = adc_avg_pkg::CNT_W'((9'd1 << avg_log2) - 9'd1);

  // ****************************************************************
  // Event input synchroniser.
  // ****************************************************************
  // The level only moves once stages two and three agree, so one glitchy
  // edge never starts two averages.
  always_comb
  begin
    next_evt_level = (evt_sync[1] == evt_sync[2]) ? evt_sync[1] : evt_level;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      evt_sync  <= 3'h0;
      evt_level <= 1'b0;
    end
    else
    begin
      evt_sync  <= {evt_sync[1:0], trig_event};
      evt_level <= next_evt_level;
    end
  end

  assign evt_rise = next_evt_level && !evt_level;

  // ****************************************************************
  // Sequencer.
  // ****************************************************************
  // Triggers are only heard while idle; start outranks the event, which
  // outranks free running.
  always_comb
  begin
    start_taken = en && (state == ST_IDLE) && ctrl[adc_avg_pkg::CTRL_START];
    trigger     = start_taken
                || (en && (state == ST_IDLE) && ctrl[adc_avg_pkg::CTRL_EVENT] && evt_rise)
                || (en && (state == ST_IDLE) && ctrl[adc_avg_pkg::CTRL_FREERUN]);
    next_state   = state;
    next_smp_cnt = smp_cnt;
    next_cur_ch  = cur_ch;
    next_result  = result;
    acc_clear    = 1'b0;
    conv_req.valid = (state == ST_ISSUE);
    conv_req.ch    = cur_ch;
    if (!ctrl[adc_avg_pkg::CTRL_SCAN] && state == ST_IDLE)
      next_cur_ch = scan_base;
    unique case (state)
      ST_IDLE:
      begin
        if (trigger)
        begin
          acc_clear    = 1'b1;
          next_smp_cnt = '0;
          next_state   = ST_ISSUE;
        end
      end
      ST_ISSUE:
        next_state = ST_CONVERT;
      ST_CONVERT:
      begin
        if (acc_added)
        begin
          if (smp_cnt == last_cnt)
            next_state = ST_FINISH;
          else
          begin
            next_smp_cnt = smp_cnt + 1'b1;
            next_state   = ST_ISSUE;
          end
        end
      end
      ST_FINISH:
      begin
        next_result = adc_avg_pkg::scale_sum(acc_sum, avg_log2, signed_mode);
        acc_clear   = 1'b1;
        next_state  = ST_IDLE;
        if (ctrl[adc_avg_pkg::CTRL_SCAN])
          next_cur_ch = (cur_ch == scan_base + scan_cnt) ? scan_base : cur_ch + 1'b1;
      end
    endcase
    // Dropping enable, or free running mid-average, flushes the sum.
    if (!en || (state != ST_IDLE && ctrl[adc_avg_pkg::CTRL_FREERUN]
                && !next_ctrl[adc_avg_pkg::CTRL_FREERUN]))
    begin
      acc_clear  = 1'b1;
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state   <= ST_IDLE;
      smp_cnt <= '0;
      cur_ch  <= '0;
      result  <= '0;
    end
    else
    begin
      state   <= next_state;
      smp_cnt <= next_smp_cnt;
      cur_ch  <= next_cur_ch;
      result  <= next_result;
    end
  end

  // ****************************************************************
  // Datapath.
  // ****************************************************************
  adc_offset_corrector u_corrector (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .raw         (conv_rsp),
    .offset      (offset),
    .offset_en   (ctrl[adc_avg_pkg::CTRL_OFFSET]),
    .signed_mode (signed_mode),
    .corr        (corr)
  );

  adc_accumulator u_accumulator (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .clear       (acc_clear),
    .signed_mode (signed_mode),
    .add         (corr),
    .sum         (acc_sum),
    .added       (acc_added)
  );

  // ****************************************************************
  // Register slave.
  // ****************************************************************
  // One wait cycle: readdata is captured on the first edge and stands while
  // waitrequest is low; writes land on the edge where waitrequest is low.
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign bus_wr          = avs_write && ack;
  assign irq             = flag && mask;

  always_comb
  begin
    next_ack       = (avs_read || avs_write) && !ack;
    next_ctrl      = ctrl;
    next_avg_log2  = avg_log2;
    next_scan_base = scan_base;
    next_scan_cnt  = scan_cnt;
    next_offset    = offset;
    next_mask      = mask;
    next_flag      = flag;
    next_readdata  = avs_readdata;
    if (start_taken)
      next_ctrl[adc_avg_pkg::CTRL_START] = 1'b0;
    if (bus_wr)
    begin
      unique case (avs_address)
        adc_avg_pkg::OFS_CTRL:   next_ctrl = avs_writedata[adc_avg_pkg::CTRL_W-1:0];
        adc_avg_pkg::OFS_AVG:    next_avg_log2 = avs_writedata[adc_avg_pkg::LOG2_W-1:0];
        adc_avg_pkg::OFS_SCAN:
        begin
          next_scan_base = avs_writedata[adc_avg_pkg::CH_W-1:0];
          next_scan_cnt  = avs_writedata[adc_avg_pkg::SCAN_CNT_LSB +: adc_avg_pkg::CH_W];
        end
        adc_avg_pkg::OFS_OFFSET: next_offset = avs_writedata[adc_avg_pkg::SAMPLE_W-1:0];
        adc_avg_pkg::OFS_FLAGS:
          if (avs_writedata[adc_avg_pkg::FLAG_DONE])
            next_flag = 1'b0;
        adc_avg_pkg::OFS_MASK:   next_mask = avs_writedata[adc_avg_pkg::FLAG_DONE];
        default:                 next_mask = mask;
      endcase
    end
    // A completion in the clearing cycle still wins.
    if (state == ST_FINISH && en)
      next_flag = 1'b1;
    if (avs_read && !ack)
    begin
      unique case (avs_address)
        adc_avg_pkg::OFS_CTRL:   next_readdata = 32'(ctrl);
        adc_avg_pkg::OFS_AVG:    next_readdata = 32'(avg_log2);
        adc_avg_pkg::OFS_SCAN:   next_readdata = 32'({scan_cnt, scan_base});
        adc_avg_pkg::OFS_OFFSET: next_readdata = 32'(offset);
        adc_avg_pkg::OFS_RESULT: next_readdata = 32'(result);
        adc_avg_pkg::OFS_FLAGS:  next_readdata = 32'(flag);
        adc_avg_pkg::OFS_MASK:   next_readdata = 32'(mask);
        adc_avg_pkg::OFS_STATUS: next_readdata = 32'({cur_ch, 3'h0, state != ST_IDLE});
        default:                 next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack          <= 1'b0;
      ctrl         <= adc_avg_pkg::CTRL_RESET;
      avg_log2     <= '0;
      scan_base    <= '0;
      scan_cnt     <= '0;
      offset       <= '0;
      mask         <= 1'b0;
      flag         <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ack          <= next_ack;
      ctrl         <= next_ctrl;
      avg_log2     <= next_avg_log2;
      scan_base    <= next_scan_base;
      scan_cnt     <= next_scan_cnt;
      offset       <= next_offset;
      mask         <= next_mask;
      flag         <= next_flag;
      avs_readdata <= next_readdata;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  logic [8:0] req_seen;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      req_seen <= '0;
    else if (state == ST_IDLE)
      req_seen <= '0;
    else if (conv_req.valid)
      req_seen <= req_seen + 9'd1;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_channel_hold: assert property (
    (state != ST_FINISH && ctrl[adc_avg_pkg::CTRL_SCAN] && !bus_wr) |=> $stable(cur_ch))
    else $error("Scan channel moved before average finished.");
  a_all_conversions: assert property (
    (state == ST_FINISH) |-> req_seen == (9'd1 << avg_log2))
    else $error("Average finished with wrong conversion count.");
  a_flag_at_end: assert property (
    $rose(flag) |-> $past(state) == ST_FINISH && result == $past(next_result))
    else $error("Done flag rose without a finished average.");
  a_event_starts: assert property (
    (state == ST_IDLE && en && ctrl[adc_avg_pkg::CTRL_EVENT] && evt_rise)
    |=> state == ST_ISSUE ##1 state == ST_CONVERT)
    else $error("Event did not start an average.");
  a_unsigned_shift: assert property (
    (state == ST_FINISH && !signed_mode)
    |=> result == adc_avg_pkg::SAMPLE_W'($past(acc_sum) >> $past(avg_log2)))
    else $error("Unsigned average not zero filled.");
  a_start_clears: assert property (
    (start_taken && !bus_wr) |=> !ctrl[adc_avg_pkg::CTRL_START] && state == ST_ISSUE)
    else $error("Start bit did not clear when taken.");
  a_disable_flush: assert property (
    !en |=> acc_sum == '0 && state == ST_IDLE)
    else $error("Disable did not flush the accumulator.");
  a_irq_cause: assert property (
    $rose(irq) |-> $past(state) == ST_FINISH || $past(bus_wr))
    else $error("Interrupt rose without a finished average or mask write.");

  c_single_avg: cover property (state == ST_FINISH && avg_log2 == 3'h3);
  c_scan_wrap: cover property (state == ST_FINISH && ctrl[adc_avg_pkg::CTRL_SCAN]
                               && cur_ch == scan_base + scan_cnt);
  c_event_run: cover property (ctrl[adc_avg_pkg::CTRL_EVENT] && evt_rise && state == ST_IDLE);

endmodule // adc_averaging_sequencer
`default_nettype wire

//--- rtl/adc_avg_pkg.sv
`default_nettype none
package adc_avg_pkg;

  // ****************************************************************
  // Widths.
  // ****************************************************************
  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned ACC_W    = 20;
  localparam int unsigned CH_W     = 4;
  localparam int unsigned LOG2_W   = 3;
  localparam int unsigned ADDR_W   = 5;
  localparam int unsigned CNT_W    = 8;

  // ****************************************************************
  // Register byte offsets.
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_AVG    = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_SCAN   = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_OFFSET = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_FLAGS  = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h1c;

  // ****************************************************************
  // Control register fields.
  // ****************************************************************
  localparam int unsigned CTRL_W        = 7;
  localparam int unsigned CTRL_ENABLE   = 0;
  localparam int unsigned CTRL_START    = 1;
  localparam int unsigned CTRL_FREERUN  = 2;
  localparam int unsigned CTRL_SCAN     = 3;
  localparam int unsigned CTRL_EVENT    = 4;
  localparam int unsigned CTRL_OFFSET   = 5;
  localparam int unsigned CTRL_SIGNED   = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
  localparam int unsigned SCAN_CNT_LSB  = 4;
  localparam int unsigned STAT_CH_LSB   = 4;
  localparam int unsigned FLAG_DONE     = 0;

  // Conversion request to the analog core and its answer.
  typedef struct packed {
    logic                valid;
    logic [CH_W-1:0]     ch;
  } conv_req_t;

  typedef struct packed {
    logic                valid;
    logic [SAMPLE_W-1:0] sample;
  } conv_rsp_t;

  // Scales the sum down by 2^k; unsigned sums shift in zeros.
  function automatic logic [SAMPLE_W-1:0] scale_sum(input logic [ACC_W-1:0] sum,
                                                    input logic [LOG2_W-1:0] k,
                                                    input logic sgn);
    logic [ACC_W-1:0] shifted;
    shifted = sgn ? ACC_W'($signed(sum) >>> k) : (sum >> k);
    return shifted[SAMPLE_W-1:0];
  endfunction

endpackage
`default_nettype wire

//--- rtl/adc_offset_corrector.sv
`default_nettype none
module adc_offset_corrector (
  // Clock and reset.
  input  wire logic                                core_clk,
  input  wire logic                                rst_b,
  // Raw sample and settings.
  input  wire adc_avg_pkg::conv_rsp_t              raw,
  input  wire logic [adc_avg_pkg::SAMPLE_W-1:0]    offset,
  input  wire logic                                offset_en,
  input  wire logic                                signed_mode,
  // Corrected sample, one cycle later.
  output adc_avg_pkg::conv_rsp_t                   corr
);

  // ****************************************************************
  // Offset subtraction.
  // ****************************************************************
  adc_avg_pkg::conv_rsp_t next_corr;

  // An unsigned sample below the offset clamps at zero instead of wrapping.
  always_comb
  begin
    next_corr.valid  = raw.valid;
    next_corr.sample = raw.sample;
    if (offset_en)
    begin
      if (!signed_mode && (raw.sample < offset))
        next_corr.sample = '0;
      else
        next_corr.sample = raw.sample - offset;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      corr <= '0;
    else
      corr <= next_corr;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_offset_subtracted: assert property (
    (raw.valid && offset_en && (signed_mode || raw.sample >= offset))
    |=> corr.sample == $past(raw.sample) - $past(offset))
    else $error("Offset not subtracted from sample.");
  a_unsigned_floor: assert property (
    (raw.valid && offset_en && !signed_mode && raw.sample < offset)
    |=> corr.valid && corr.sample == '0)
    else $error("Negative unsigned result not clamped to zero.");

endmodule // adc_offset_corrector
`default_nettype wire

//--- sim/adc_averaging_sequencer_tb.sv
`default_nettype none
module adc_averaging_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ********
  // Signals.
  // ********
  logic                   core_clk = 1'b0;
  logic                   rst_b = 1'b0;
  logic [4:0]             avs_address = 5'h00;
  logic                   avs_read = 1'b0;
  logic                   avs_write = 1'b0;
  logic [31:0]            avs_writedata = 32'h0;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  adc_avg_pkg::conv_req_t conv_req;
  adc_avg_pkg::conv_rsp_t conv_rsp = '0;
  logic                   trig_event = 1'b0;
  logic                   irq;
  logic [1:0]             pend = 2'h0;
  logic [11:0]            smp = 12'h000;
  logic [3:0]             chq[$];
  int                     rsp_count = 0;
  int                     cycles = 0;
  int                     bad_count = 0;
  int                     num_checks = 0;

  // The clock toggles every 12.5 ns, half of its 25 ns period.
  always #12.5 core_clk = ~core_clk;

  adc_averaging_sequencer dut (
    .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .conv_req(conv_req), .conv_rsp(conv_rsp),
    .trig_event(trig_event), .irq(irq)
  );

  // ********
  // Analog core stand-in.
  // ********
  // Answers each request three cycles later; idle sample bits toggle so stale data never matches.
  always @(posedge core_clk)
  begin
    pend <= {pend[0], conv_req.valid === 1'b1};
    conv_rsp.valid <= pend[1];
    conv_rsp.sample <= pend[1] ? smp : ~conv_rsp.sample;
    if (conv_req.valid === 1'b1)
      chq.push_back(conv_req.ch);
    if (pend[1])
      rsp_count++;
  end

  // A hang is cut short well beyond the few hundred cycles the tests need.
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      test_done();
    end
  end

  // ********
  // Tasks.
  // ********
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon access; waitrequest is sampled at each rising edge, and the edge
  // that sees it low is the one where the write lands and read data is taken.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  // Writes a start and polls until the start bit has cleared itself.
  task automatic run(input logic [31:0] c);
    logic [31:0] q;
    wr(adc_avg_pkg::OFS_CTRL, c);
    q = 32'h2;
    while (q[1] !== 1'b0)
      bus(1'b0, adc_avg_pkg::OFS_CTRL, 32'h0, q);
    rd_chk(adc_avg_pkg::OFS_CTRL, c & 32'hfffffffd);
  endtask

  // Polls until the done flag reads set; the caller clears it.
  task automatic wait_done();
    logic [31:0] q;
    q = 32'h0;
    while (q[0] !== 1'b1)
      bus(1'b0, adc_avg_pkg::OFS_FLAGS, 32'h0, q);
  endtask

  // ********
  // Test sequence.
  // ********
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    rd_chk(adc_avg_pkg::OFS_CTRL, 32'h0);
    rd_chk(adc_avg_pkg::OFS_RESULT, 32'h0);
    rd_chk(5'h06, 32'h0);
    wr(adc_avg_pkg::OFS_MASK, 32'h1);
    rd_chk(adc_avg_pkg::OFS_MASK, 32'h1);
    $display("test registers done");
    // Four samples from one start; nothing flagged before the last one.
    // Three full-scale samples then a small one: a zero-extended sum reads 0xc00.
    wr(adc_avg_pkg::OFS_AVG, 32'h2);
    smp = 12'hfff;
    rsp_count = 0;
    chq.delete();
    run(32'h3);
    while (rsp_count < 3)
      @(posedge core_clk);
    smp = 12'h003;
    rd_chk(adc_avg_pkg::OFS_FLAGS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wait_done();
    chk({31'h0, irq}, 32'h1);
    rd_chk(adc_avg_pkg::OFS_RESULT, 32'hc00);
    chk(chq.size(), 32'h4);
    wr(adc_avg_pkg::OFS_FLAGS, 32'h1);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    $display("test single start done");
    // One event runs a two-sample average.
    wr(adc_avg_pkg::OFS_AVG, 32'h1);
    smp = 12'h123;
    chq.delete();
    wr(adc_avg_pkg::OFS_CTRL, 32'h11);
    trig_event <= 1'b1;
    repeat (4) @(posedge core_clk);
    trig_event <= 1'b0;
    wait_done();
    chk(chq.size(), 32'h2);
    rd_chk(adc_avg_pkg::OFS_RESULT, 32'h123);
    wr(adc_avg_pkg::OFS_FLAGS, 32'h1);
    wr(adc_avg_pkg::OFS_CTRL, 32'h1);
    $display("test event done");
    // Scan over channels 2 and 3: a channel keeps its place for its whole average.
    wr(adc_avg_pkg::OFS_SCAN, 32'h12);
    chq.delete();
    run(32'hb);
    wait_done();
    rd_chk(adc_avg_pkg::OFS_STATUS, 32'h30);
    wr(adc_avg_pkg::OFS_FLAGS, 32'h1);
    run(32'hb);
    wait_done();
    wr(adc_avg_pkg::OFS_FLAGS, 32'h1);
    chk(chq.size(), 32'h4);
    for (int i = 0; i < chq.size() && i < 4; i++)
      chk({28'h0, chq[i]}, (i < 2) ? 32'h2 : 32'h3);
    wr(adc_avg_pkg::OFS_SCAN, 32'h0);
    $display("test scan done");
    // Offset below and above the sample in unsigned mode.
    wr(adc_avg_pkg::OFS_AVG, 32'h0);
    wr(adc_avg_pkg::OFS_OFFSET, 32'h10);
    smp = 12'h008;
    run(32'h23);
    wait_done();
    rd_chk(adc_avg_pkg::OFS_RESULT, 32'h0);
    wr(adc_avg_pkg::OFS_FLAGS, 32'h1);
    smp = 12'h100;
    run(32'h23);
    wait_done();
    rd_chk(adc_avg_pkg::OFS_RESULT, 32'hf0);
    wr(adc_avg_pkg::OFS_FLAGS, 32'h1);
    $display("test offset done");
    // Disable mid-average; stale partial sums would lift the next result.
    wr(adc_avg_pkg::OFS_AVG, 32'h2);
    smp = 12'h040;
    rsp_count = 0;
    run(32'h3);
    while (rsp_count < 2)
      @(posedge core_clk);
    wr(adc_avg_pkg::OFS_CTRL, 32'h0);
    repeat (10) @(posedge core_clk);
    rd_chk(adc_avg_pkg::OFS_STATUS, 32'h0);
    smp = 12'h100;
    run(32'h3);
    wait_done();
    rd_chk(adc_avg_pkg::OFS_RESULT, 32'h100);
    $display("test flush done");
    // Free running repeats averages until it is dropped, then stays idle.
    wr(adc_avg_pkg::OFS_FLAGS, 32'h1);
    smp = 12'h080;
    wr(adc_avg_pkg::OFS_CTRL, 32'h5);
    wait_done();
    wr(adc_avg_pkg::OFS_CTRL, 32'h1);
    repeat (40) @(posedge core_clk);
    rd_chk(adc_avg_pkg::OFS_STATUS, 32'h0);
    rd_chk(adc_avg_pkg::OFS_RESULT, 32'h080);
    $display("test free run done");
    // Signed averages keep their sign through the shift.
    wr(adc_avg_pkg::OFS_FLAGS, 32'h1);
    smp = 12'hf00;
    run(32'h43);
    wait_done();
    rd_chk(adc_avg_pkg::OFS_RESULT, 32'hf00);
    $display("test signed done");
    test_done();
  end
endmodule // adc_averaging_sequencer_tb
`default_nettype wire
